//--- core/scg_clock_ctrl.sv
// Secondary clock gating and clock-run control with an APB register slave.
// How it works
// - slot 0 output stops on code 11
// - slot 1 output stops on code 11
// - slot 2 output stops on code 11
// - slot 3 output stops on code 11
// - device 1 output stops on bit 8
// - device 2 output stops on bit 9
// - feedback output stops on bit 10
// - enables act in forward mode only
// - bit 13 shows clock stopped
// - bit 14 enables; mode 0 D3hot
// - mode 1 stops on idle bus with no primary request pending
// - D3 taken from power state field
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module scg_clock_ctrl
	import scg_pkg::*;
#(
	parameter int HALF_CYC = SCG_HALF_CYC
) (
	input  wire logic                MCLK,
	input  wire logic                RSTN,
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [11:0]         PADDR,
	input  wire logic [31:0]         PWDATA,
	output var  logic [31:0]         PRDATA,
	output var  logic                PREADY,
	output var  logic                PSLVERR,
	input  wire logic                FORWARD_MODE,
	input  wire logic                SEC_BUS_IDLE,
	input  wire logic                PRI_REQ_PENDING,
	output var  logic [SCG_NOUT-1:0] CLOCK_OUT,
	output var  logic                SEC_CLOCK_STOPPED
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	logic       fwd;
	logic       idle;
	logic       preq;
	// First stage feeds only the second stage.
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
		end else begin
			meta_r <= {PRI_REQ_PENDING, SEC_BUS_IDLE, FORWARD_MODE};
			sync_r <= meta_r;
		end
	end
	assign fwd  = sync_r[0];
	assign idle = sync_r[1];
	assign preq = sync_r[2];

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic [31:0] ctl_r;
	logic [1:0]  pstate_r;
	logic        stopped_r;
	logic        acc;
	logic        hit_clk;
	logic        hit_pm;
	logic [31:0] rd;
	assign acc     = PSEL & PENABLE & PREADY;
	assign hit_clk = (PADDR == SCG_CLK_OFS);
	assign hit_pm  = (PADDR == SCG_PM_OFS);

	// Read view; status bit comes from the gating state.
	always_comb begin
		rd = 32'h0000_0000;
		if (hit_clk) begin
			rd = ctl_r & SCG_RW_MASK;
			rd[SCG_STOP_BIT] = stopped_r;
		end else if (hit_pm) begin
			rd[1:0] = pstate_r;
		end
	end

	// One wait state keeps every answer straight from a flop.
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL & PENABLE & ~PREADY;
			PRDATA  <= rd;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~(hit_clk | hit_pm);
		end
	end

	// Control register write, reserved bits dropped.
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ctl_r <= SCG_CLK_RST;
		end else if (acc && PWRITE && hit_clk) begin
			ctl_r <= PWDATA & SCG_RW_MASK;
		end
	end

	// Power state; codes 01 and 10 are not implemented and ignored.
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			pstate_r <= SCG_PM_RST;
		end else if (acc && PWRITE && hit_pm) begin
			if (PWDATA[1:0] == SCG_PS_D0 || PWDATA[1:0] == SCG_PS_D3) begin
				pstate_r <= PWDATA[1:0];
			end
		end
	end

	// ----------------------------------------
	// Clock-run decision
	// ----------------------------------------
	logic stop_req;
	always_comb begin
		stop_req = 1'b0;
		if (ctl_r[SCG_RUN_EN]) begin
			if (ctl_r[SCG_RUN_MODE]) begin
				stop_req = idle & ~preq;
			end else begin
				stop_req = (pstate_r == SCG_PS_D3);
			end
		end
	end

	// ----------------------------------------
	// Secondary clock divider and stop state
	// ----------------------------------------
	logic [7:0] div_r;
	logic       tick;
	logic       phase_r;
	scg_state_t state_r;
	assign tick = (div_r == 8'(HALF_CYC - 1));

	// Divider gives a one-cycle enable per half period.
	always_ff @(posedge MCLK) begin
		if (!RSTN || tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// Stop only at a low phase so no output sees a runt pulse.
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			state_r <= SCG_RUN;
			phase_r <= 1'b0;
		end else if (tick) begin
			unique case (state_r)
				SCG_RUN: begin
					if (!phase_r && stop_req) begin
						state_r <= SCG_STOP;
					end else begin
						phase_r <= ~phase_r;
					end
				end
				SCG_STOP: begin
					if (!stop_req) begin
						state_r <= SCG_RUN;
						phase_r <= 1'b1;
					end
				end
				default: state_r <= SCG_RUN;
			endcase
		end
	end
	assign stopped_r = (state_r == SCG_STOP);

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			SEC_CLOCK_STOPPED <= 1'b0;
		end else begin
			SEC_CLOCK_STOPPED <= stopped_r;
		end
	end

	// ----------------------------------------
	// Per-output gating
	// ----------------------------------------
	logic [SCG_NOUT-1:0] off;
	genvar g;
	generate
		for (g = 0; g < SCG_NOUT; g++) begin : gen_out
			if (g < SCG_NSLOT) begin : gen_slot
				assign off[g] = (ctl_r[2*g+1:2*g] == SCG_SLOT_OFF);
			end else begin : gen_dev
				assign off[g] = ctl_r[SCG_DEV_LSB+g-SCG_NSLOT];
			end
			always_ff @(posedge MCLK) begin
				if (!RSTN) begin
					CLOCK_OUT[g] <= 1'b0;
				end else begin
					CLOCK_OUT[g] <= phase_r & ~(fwd & off[g]);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_wr_clk;
		acc && PWRITE && hit_clk;
	endsequence
	sequence s_rd_clk;
		PSEL && PENABLE && !PREADY && !PWRITE && hit_clk;
	endsequence

	a_slot_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[1:0] == SCG_SLOT_OFF) |=> !CLOCK_OUT[0])
		else $error("slot 0 clock not low");
	a_slot1_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[3:2] == SCG_SLOT_OFF) |=> !CLOCK_OUT[1])
		else $error("slot 1 clock not low");
	a_slot2_run: assert property (@(posedge MCLK) disable iff (!RSTN)
		(ctl_r[5:4] != SCG_SLOT_OFF) |=> CLOCK_OUT[2] == $past(phase_r))
		else $error("slot 2 clock not following");
	a_slot3_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[7:6] == SCG_SLOT_OFF) |=> !CLOCK_OUT[3])
		else $error("slot 3 clock not low");
	a_dev_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[8]) |=> !CLOCK_OUT[4])
		else $error("device 1 clock not low");
	a_dev2_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[9]) |=> !CLOCK_OUT[5])
		else $error("device 2 clock not low");
	a_fb_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[10]) |=> !CLOCK_OUT[6])
		else $error("feedback clock not low");
	a_reverse_run: assert property (@(posedge MCLK) disable iff (!RSTN)
		!fwd |=> CLOCK_OUT == {SCG_NOUT{$past(phase_r)}})
		else $error("reverse mode gated a clock");
	a_stat_read: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_rd_clk |=> PRDATA[SCG_STOP_BIT] == $past(stopped_r))
		else $error("stop status wrong");
	a_run_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		!ctl_r[SCG_RUN_EN] && !stopped_r |=> !stopped_r)
		else $error("clock stopped with protocol off");
	a_idle_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
		(!stopped_r && tick && !phase_r && stop_req && ctl_r[SCG_RUN_MODE])
		|=> stopped_r)
		else $error("idle bus did not stop clock");
	a_pm_ignore: assert property (@(posedge MCLK) disable iff (!RSTN)
		(acc && PWRITE && hit_pm && PWDATA[1:0] inside {2'h1, 2'h2})
		|=> $stable(pstate_r))
		else $error("bad power state accepted");
	a_resv_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_wr_clk |=> (ctl_r & ~SCG_RW_MASK) == 32'h0000_0000)
		else $error("reserved bits stored");

	// These checks tie stop and bus answers to the pins, not to stop_req alone; the stop-low and restart checks key on stop_req.
	sequence s_stop_entry;
		!stopped_r && tick && !phase_r && stop_req;
	endsequence
	sequence s_restart;
		stopped_r && tick && !stop_req;
	endsequence

	a_slot2_off: assert property (@(posedge MCLK) disable iff (!RSTN)
		(fwd && ctl_r[5:4] == SCG_SLOT_OFF) |=> !CLOCK_OUT[2])
		else $error("slot 2 clock not low");
	a_d3_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
		(ctl_r[SCG_RUN_EN] && !ctl_r[SCG_RUN_MODE] && pstate_r == SCG_PS_D3
		&& !stopped_r && tick && !phase_r) |=> stopped_r)
		else $error("power state did not stop clock");
	a_idle_pins: assert property (@(posedge MCLK) disable iff (!RSTN)
		(ctl_r[SCG_RUN_EN] && ctl_r[SCG_RUN_MODE] && idle && !preq
		&& !stopped_r && tick && !phase_r) |=> stopped_r)
		else $error("idle pins did not stop clock");
	a_stop_low: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_stop_entry |=> stopped_r ##1 (CLOCK_OUT == '0 && SEC_CLOCK_STOPPED))
		else $error("stopped clocks not low");
	a_restart_high: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_restart |=> !stopped_r && phase_r)
		else $error("restart not on high phase");
	a_stat_pin: assert property (@(posedge MCLK) disable iff (!RSTN)
		1'b1 |=> SEC_CLOCK_STOPPED == $past(stopped_r))
		else $error("stop status pin lags");
	a_unmapped_err: assert property (@(posedge MCLK) disable iff (!RSTN)
		(PSEL && PENABLE && !PREADY && !hit_clk && !hit_pm)
		|=> (PSLVERR && PREADY && PRDATA == 32'h0000_0000))
		else $error("unmapped access not refused");
	a_ctl_write: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_wr_clk |=> ctl_r == ($past(PWDATA) & SCG_RW_MASK))
		else $error("control write lost");
endmodule : scg_clock_ctrl
`default_nettype wire

//--- core/scg_pkg.sv
// Package with register map, field layout and timing constants for clock gating control.
package scg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] SCG_PM_OFS  = 12'h094;
	localparam logic [11:0] SCG_CLK_OFS = 12'h0A4;
	localparam logic [31:0] SCG_CLK_RST = 32'h0000_0000;
	localparam logic [1:0]  SCG_PM_RST  = 2'h0;
	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int SCG_NOUT     = 7;
	localparam int SCG_NSLOT    = 4;
	localparam int SCG_DEV_LSB  = 8;
	localparam int SCG_STOP_BIT = 13;
	localparam int SCG_RUN_EN   = 14;
	localparam int SCG_RUN_MODE = 15;
	localparam logic [31:0] SCG_RW_MASK = 32'h0000_C7FF;
	localparam logic [1:0]  SCG_SLOT_OFF = 2'h3;
	localparam logic [1:0]  SCG_PS_D0 = 2'h0;
	localparam logic [1:0]  SCG_PS_D3 = 2'h3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SCG_MCLK_MHZ = 125;
	localparam int SCG_SEC_MHZ  = 62;
	localparam int SCG_HALF_CYC = (SCG_MCLK_MHZ / SCG_SEC_MHZ) / 2;
	typedef enum logic [1:0] {
		SCG_RUN  = 2'b00,
		SCG_STOP = 2'b01
	} scg_state_t;
endpackage : scg_pkg

//--- tb/scg_slot_model.sv
// Model of the slots and devices that receive the gated clocks.
`timescale 1ns/1ps
`default_nettype none
module scg_slot_model
	import scg_pkg::*;
(
	input  wire logic                MCLK,
	input  wire logic                CLEAR,
	input  wire logic                BUSY,
	input  wire logic [SCG_NOUT-1:0] CLOCK_OUT,
	output var  logic [SCG_NOUT-1:0] SEEN_RISE,
	output var  logic                SEC_BUS_IDLE
);
	logic [SCG_NOUT-1:0] prev_r;
	// Rising edges are remembered until cleared, so a glitch is not missed.
	always_ff @(posedge MCLK) begin
		prev_r <= CLOCK_OUT;
		SEEN_RISE <= CLEAR ? '0 : (SEEN_RISE | (CLOCK_OUT & ~prev_r));
	end
	// A busy target reports the bus as not idle one cycle later.
	always_ff @(posedge MCLK) begin
		SEC_BUS_IDLE <= !BUSY;
	end
endmodule : scg_slot_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the secondary clock gating control block.
`timescale 1ns/1ps
`default_nettype none
module testbench import scg_pkg::*;;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
	logic        fwd, req, idle, busy, clr, stopped, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [6:0]  outs, seen;
	int          errors, checks, ctl, pm, i;
	scg_clock_ctrl #(.HALF_CYC(1)) DUT (.MCLK(mclk), .RSTN(rstn), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FORWARD_MODE(fwd),
		.SEC_BUS_IDLE(idle), .PRI_REQ_PENDING(req), .CLOCK_OUT(outs),
		.SEC_CLOCK_STOPPED(stopped));
	scg_slot_model PEER (.MCLK(mclk), .CLEAR(clr), .BUSY(busy), .CLOCK_OUT(outs),
		.SEEN_RISE(seen), .SEC_BUS_IDLE(idle));
	// Behavioural model of the expected stop state and gate mask.
	function automatic logic stop_exp();
		return ctl[14] && (ctl[15] ? (!busy && !req) : (pm == 3));
	endfunction : stop_exp
	function automatic logic [6:0] gate_exp();
		logic [6:0] g;
		for (int s = 0; s < 4; s++) g[s] = (ctl[2*s+:2] == 2'h3);
		g[6:4] = ctl[10:8];
		return stop_exp() ? 7'h7F : (fwd ? g : 7'h00);
	endfunction : gate_exp
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until pready is seen, then lets one edge pass; only the watchdog ends a wait.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic x);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
		chk({31'h0, err}, {31'h0, x});
	endtask : rdchk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		chk({31'h0, err}, {31'h0, a != SCG_CLK_OFS && a != SCG_PM_OFS});
		if (a == SCG_CLK_OFS) ctl = d & SCG_RW_MASK;
		if (a == SCG_PM_OFS && (d[1:0] == 2'h0 || d[1:0] == 2'h3)) pm = d[1:0];
	endtask : wr
	// Lets the gates settle, then watches every output for 16 cycles.
	task automatic clocks();
		repeat (8) @(posedge mclk);
		clr <= 1'h1;
		@(posedge mclk);
		clr <= 1'h0;
		repeat (16) @(posedge mclk);
		chk({25'h0, seen}, {25'h0, ~gate_exp()});
		chk({25'h0, outs & gate_exp()}, 32'h0);
		chk({31'h0, stopped}, {31'h0, stop_exp()});
		rdchk(SCG_CLK_OFS, ctl | (32'(stop_exp()) << 13), 1'h0);
	endtask : clocks
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	// The tests need about 1000 cycles; twenty times that marks a hang.
	initial begin
		#160000;
		errors++;
		complete_run();
	end
	initial begin
		{rstn, psel, penable, pwrite, clr, busy} = '0;
		{fwd, req} = 2'h3;
		paddr = '0;
		pwdata = '0;
		seed = 32'h0001_3C62;
		{ctl, pm, errors, checks} = '0;
		repeat (20) @(posedge mclk);
		rstn <= 1'h1;
		rdchk(SCG_CLK_OFS, 32'h0, 1'h0);
		rdchk(SCG_PM_OFS, 32'h0, 1'h0);
		clocks();
		$display("reset test done");
		for (i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(SCG_CLK_OFS, seed);
			clocks();
		end
		for (i = 0; i < 15; i++) begin
			wr(SCG_CLK_OFS, (i < 12) ? ((i % 3 + 1) << (2 * (i / 3))) : (1 << (i - 4)));
			clocks();
		end
		$display("gate test done");
		fwd <= 1'h0;
		wr(SCG_CLK_OFS, 32'h7FF);
		clocks();
		fwd <= 1'h1;
		wr(SCG_PM_OFS, 32'h1);
		rdchk(SCG_PM_OFS, 32'h0, 1'h0);
		wr(SCG_PM_OFS, 32'h3);
		clocks();
		wr(SCG_CLK_OFS, 32'h4000);
		clocks();
		wr(SCG_PM_OFS, 32'h0);
		clocks();
		wr(SCG_CLK_OFS, 32'hC000);
		clocks();
		req <= 1'h0;
		clocks();
		busy <= 1'h1;
		clocks();
		$display("clock run test done");
		rdchk(12'h0F0, 32'h0, 1'h1);
		wr(12'h0F0, 32'hFFFF);
		rdchk(SCG_CLK_OFS, ctl | (32'(stop_exp()) << 13), 1'h0);
		$display("unmapped test done");
		// A reset in mid-run must bring every field back to zero.
		wr(SCG_CLK_OFS, 32'hC7FF);
		rstn <= 1'h0;
		repeat (2) @(posedge mclk);
		rstn <= 1'h1;
		{ctl, pm} = '0;
		rdchk(SCG_CLK_OFS, 32'h0, 1'h0);
		rdchk(SCG_PM_OFS, 32'h0, 1'h0);
		clocks();
		$display("second reset test done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire
